// ---- uarx_top.sv ----
// Asynchronous receive port with address detect, wake-up and APB registers
// Contract
// R01 - Software loads divisor and speed bits first
// R02 - Software clears sync, sets port enable
// R03 - Software picks receive priority before enabling
// R04 - Nine-bit, then address detect, then receive
// R05 - Address detect drops non-address characters silently
// R06 - Address detect loads only ninth-bit-one characters
// R07 - Flag on completion; interrupt needs both enables
// R08 - Ninth bit and errors readable in status
// R09 - Software reads data to check address
// R10 - Clearing continuous receive clears latched errors
// R11 - Sleep halts baud generator and reception
// R12 - Wake enable suspends reception, watches line
// R13 - Falling line edge is the wake event
// R14 - Wake event sets the receive flag
// R15 - Reading received data clears the flag
// R16 - First rising edge clears wake enable
// R17 - Remote sends all-zero first character
// R18 - Remote break long enough for start-up
// R19 - Line sampled at sixteen times bit rate
// R20 - Idle status shows reception in progress
`timescale 1ns/1ps
`default_nettype none
`include "uarx_regs.svh"
module uarx_top import uarx_pkg::*; (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Serial line and power state
	input wire logic rxLine,
	input wire logic sleepReq,
	// Interrupt request to the core
	output logic rxIrq,
	output logic rxIrqHighPri
);
	// ==========================================================
	// Declarations
	logic portEnable, nineBit, contEnable, addrDetect, syncMode, highSpeed, sixteenBit, wakeEnable;
	logic rxIe, rxIp, globalIe;
	logic [7:0] divHigh, divLow;
	logic next_portEnable, next_nineBit, next_contEnable, next_addrDetect, next_syncMode;
	logic next_highSpeed, next_sixteenBit, next_wakeEnable, next_rxIe, next_rxIp, next_globalIe;
	logic [7:0] next_divHigh, next_divLow;
	logic lineMeta, lineQ, linePrev;
	logic next_pready, next_pslverr;
	logic [31:0] next_prdata, rdVal;
	logic rdHit, wrDone, rdDone, dataRead, tick, rxOk, wakeActive, fallEdge, riseEdge;
	uarx_state_t rxState, next_rxState;
	logic [3:0] tickCnt, next_tickCnt, bitCnt, next_bitCnt;
	logic [8:0] shiftReg, next_shiftReg;
	logic [7:0] rxData, next_rxData;
	logic received_ninth_bit, next_received_ninth_bit, framing_error, next_framing_error, overrun_error, next_overrun_error, rxFlag, next_rxFlag;
	logic wakeSeen, next_wakeSeen, wakeClear, charDone, keepChar, loadChar;
	logic [7:0] charByte;
	logic charNinth;

	// ==========================================================
	// Line synchroniser
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			lineMeta <= 1'b1;
			lineQ <= 1'b1;
			linePrev <= 1'b1;
		end else begin
			lineMeta <= rxLine;
			lineQ <= lineMeta;
			linePrev <= lineQ;
		end
	end

	assign fallEdge = linePrev & ~lineQ;
	assign riseEdge = ~linePrev & lineQ;

	// ==========================================================
	// APB slave, one wait state so read data comes from a flop
	assign wrDone = psel & penable & pready & pwrite;
	assign rdDone = psel & penable & pready & ~pwrite;
	assign dataRead = rdDone & (paddr == `UARX_OFF_RX_DATA);

	always_comb begin
		rdVal = `UARX_RST_WORD;
		rdHit = 1'b1;
		case (paddr)
			`UARX_OFF_RX_STATUS: begin
				rdVal[`UARX_RS_PORT_EN] = portEnable;
				rdVal[`UARX_RS_NINE_EN] = nineBit;
				rdVal[`UARX_RS_CONT_EN] = contEnable;
				rdVal[`UARX_RS_ADDR_EN] = addrDetect;
				rdVal[`UARX_RS_FRAME_ERR] = framing_error; // R08
				rdVal[`UARX_RS_OVER_ERR] = overrun_error; // R08
				rdVal[`UARX_RS_NINTH] = received_ninth_bit; // R08
			end
			`UARX_OFF_RX_DATA: rdVal[7:0] = rxData;
			`UARX_OFF_TX_STATUS: begin
				rdVal[`UARX_TS_SYNC] = syncMode;
				rdVal[`UARX_TS_HIGH_SPEED] = highSpeed;
			end
			`UARX_OFF_BAUD_CTRL: begin
				rdVal[`UARX_BC_IDLE] = (rxState == RX_IDLE); // R20
				rdVal[`UARX_BC_SIXTEEN] = sixteenBit;
				rdVal[`UARX_BC_WAKE] = wakeEnable;
			end
			`UARX_OFF_DIV_HIGH: rdVal[7:0] = divHigh;
			`UARX_OFF_DIV_LOW: rdVal[7:0] = divLow;
			`UARX_OFF_INT_CTRL: begin
				rdVal[`UARX_IC_RX_IE] = rxIe;
				rdVal[`UARX_IC_RX_IP] = rxIp;
				rdVal[`UARX_IC_GLOBAL_IE] = globalIe;
			end
			default: rdHit = 1'b0;
		endcase
		next_pready = psel & penable & ~pready;
		next_prdata = prdata;
		next_pslverr = 1'b0;
		if (psel & penable & ~pready) begin
			next_prdata = pwrite ? `UARX_RST_WORD : rdVal;
			next_pslverr = ~rdHit;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			pready <= 1'b0;
			prdata <= `UARX_RST_WORD;
			pslverr <= 1'b0;
		end else begin
			pready <= next_pready;
			prdata <= next_prdata;
			pslverr <= next_pslverr;
		end
	end

	// ==========================================================
	// Configuration registers
	always_comb begin
		next_portEnable = portEnable;
		next_nineBit = nineBit;
		next_contEnable = contEnable;
		next_addrDetect = addrDetect;
		next_syncMode = syncMode;
		next_highSpeed = highSpeed;
		next_sixteenBit = sixteenBit;
		next_wakeEnable = wakeEnable;
		next_divHigh = divHigh;
		next_divLow = divLow;
		next_rxIe = rxIe;
		next_rxIp = rxIp;
		next_globalIe = globalIe;
		if (wakeClear) begin
			next_wakeEnable = 1'b0; // R16
		end
		if (wrDone) begin
			case (paddr)
				`UARX_OFF_RX_STATUS: begin
					next_portEnable = pwdata[`UARX_RS_PORT_EN];
					next_nineBit = pwdata[`UARX_RS_NINE_EN];
					next_contEnable = pwdata[`UARX_RS_CONT_EN];
					next_addrDetect = pwdata[`UARX_RS_ADDR_EN];
				end
				`UARX_OFF_TX_STATUS: begin
					next_syncMode = pwdata[`UARX_TS_SYNC];
					next_highSpeed = pwdata[`UARX_TS_HIGH_SPEED];
				end
				`UARX_OFF_BAUD_CTRL: begin
					next_sixteenBit = pwdata[`UARX_BC_SIXTEEN];
					next_wakeEnable = pwdata[`UARX_BC_WAKE];
				end
				`UARX_OFF_DIV_HIGH: next_divHigh = pwdata[7:0];
				`UARX_OFF_DIV_LOW: next_divLow = pwdata[7:0];
				`UARX_OFF_INT_CTRL: begin
					next_rxIe = pwdata[`UARX_IC_RX_IE];
					next_rxIp = pwdata[`UARX_IC_RX_IP];
					next_globalIe = pwdata[`UARX_IC_GLOBAL_IE];
				end
				default: next_portEnable = portEnable;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			portEnable <= 1'b0;
			nineBit <= 1'b0;
			contEnable <= 1'b0;
			addrDetect <= 1'b0;
			syncMode <= 1'b0;
			highSpeed <= 1'b0;
			sixteenBit <= 1'b0;
			wakeEnable <= 1'b0;
			divHigh <= `UARX_RST_BYTE;
			divLow <= `UARX_RST_BYTE;
			rxIe <= 1'b0;
			rxIp <= 1'b0;
			globalIe <= 1'b0;
		end else begin
			portEnable <= next_portEnable;
			nineBit <= next_nineBit;
			contEnable <= next_contEnable;
			addrDetect <= next_addrDetect;
			syncMode <= next_syncMode;
			highSpeed <= next_highSpeed;
			sixteenBit <= next_sixteenBit;
			wakeEnable <= next_wakeEnable;
			divHigh <= next_divHigh;
			divLow <= next_divLow;
			rxIe <= next_rxIe;
			rxIp <= next_rxIp;
			globalIe <= next_globalIe;
		end
	end

	// ==========================================================
	// Sample tick, stopped in sleep
	uarx_baud u_baud (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.run(portEnable & ~syncMode & ~sleepReq), // R11
		.fastMode(highSpeed | sixteenBit),
		.divisor(sixteenBit ? {divHigh, divLow} : {8'h00, divLow}),
		.tick(tick) // R19
	);

	// ==========================================================
	// Receiver and wake-up
	// Overrun halts reception until continuous receive is cycled
	assign rxOk = portEnable & ~syncMode & contEnable & ~wakeEnable & ~sleepReq & ~overrun_error; // R11 R12
	assign wakeActive = wakeEnable & portEnable & ~syncMode; // R12
	assign charByte = nineBit ? shiftReg[7:0] : shiftReg[8:1];
	assign charNinth = nineBit & shiftReg[8];
	assign charDone = (rxState == RX_STOP) & tick & (tickCnt == `UARX_TICK_LAST);
	assign keepChar = ~(addrDetect & nineBit & ~charNinth); // R05 R06
	assign loadChar = charDone & keepChar & (~rxFlag | dataRead);
	assign wakeClear = wakeSeen & riseEdge; // R16

	always_comb begin
		next_rxState = rxState;
		next_tickCnt = tickCnt;
		next_bitCnt = bitCnt;
		next_shiftReg = shiftReg;
		next_rxData = rxData;
		next_received_ninth_bit = received_ninth_bit;
		next_framing_error = framing_error;
		next_overrun_error = overrun_error;
		next_rxFlag = rxFlag;
		next_wakeSeen = wakeSeen;
		if (tick) begin
			case (rxState)
				RX_IDLE: begin
					if (!lineQ) begin
						next_rxState = RX_START;
						next_tickCnt = 4'h0;
					end
				end
				RX_START: begin
					next_tickCnt = tickCnt + 4'h1;
					if (tickCnt == `UARX_TICK_MID) begin
						next_rxState = lineQ ? RX_IDLE : RX_DATA;
						next_tickCnt = 4'h0;
						next_bitCnt = 4'h0;
					end
				end
				RX_DATA: begin
					next_tickCnt = tickCnt + 4'h1;
					if (tickCnt == `UARX_TICK_LAST) begin
						next_shiftReg = {lineQ, shiftReg[8:1]};
						next_bitCnt = bitCnt + 4'h1;
						if (bitCnt == (nineBit ? `UARX_LAST_BIT9 : `UARX_LAST_BIT8)) begin
							next_rxState = RX_STOP;
						end
					end
				end
				RX_STOP: begin
					next_tickCnt = tickCnt + 4'h1;
					if (tickCnt == `UARX_TICK_LAST) begin
						next_rxState = RX_IDLE;
					end
				end
				default: next_rxState = RX_IDLE;
			endcase
		end
		if (!rxOk) begin
			next_rxState = RX_IDLE; // R11 R12
		end
		if (dataRead) begin
			next_rxFlag = 1'b0; // R15
		end
		if (loadChar) begin
			next_rxData = charByte;
			next_received_ninth_bit = charNinth; // R08
			next_framing_error = ~lineQ;
			next_rxFlag = 1'b1; // R07
		end else if (charDone & keepChar) begin
			next_overrun_error = 1'b1;
		end
		if (wakeActive & ~wakeSeen & fallEdge) begin
			next_wakeSeen = 1'b1; // R13
			next_rxFlag = 1'b1; // R14
		end
		if (wakeClear | ~wakeEnable) begin
			next_wakeSeen = 1'b0;
		end
		if (!contEnable) begin
			next_framing_error = 1'b0; // R10
			next_overrun_error = 1'b0; // R10
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			rxState <= RX_IDLE;
			tickCnt <= 4'h0;
			bitCnt <= 4'h0;
			shiftReg <= 9'h000;
			rxData <= `UARX_RST_BYTE;
			received_ninth_bit <= 1'b0;
			framing_error <= 1'b0;
			overrun_error <= 1'b0;
			rxFlag <= 1'b0;
			wakeSeen <= 1'b0;
		end else begin
			rxState <= next_rxState;
			tickCnt <= next_tickCnt;
			bitCnt <= next_bitCnt;
			shiftReg <= next_shiftReg;
			rxData <= next_rxData;
			received_ninth_bit <= next_received_ninth_bit;
			framing_error <= next_framing_error;
			overrun_error <= next_overrun_error;
			rxFlag <= next_rxFlag;
			wakeSeen <= next_wakeSeen;
		end
	end

	assign rxIrq = rxFlag & rxIe & globalIe; // R07
	assign rxIrqHighPri = rxFlag & rxIe & globalIe & rxIp;

	// ==========================================================
	// Checks
	sequence seqWakeFall;
		wakeActive && !wakeSeen && fallEdge;
	endsequence

	sequence seqWakeRise;
		wakeSeen && riseEdge;
	endsequence

	a_irq_gating: assert property (@(posedge sys_clk) disable iff (!rst_n) // R07
		(!rxIe || !globalIe) |-> !rxIrq) else $error("Interrupt raised without both enables");
	a_addr_drop: assert property (@(posedge sys_clk) disable iff (!rst_n) // R05
		(charDone && addrDetect && nineBit && !charNinth) |=> $stable(rxData)) else $error("Data character loaded");
	a_addr_load: assert property (@(posedge sys_clk) disable iff (!rst_n) // R06
		(charDone && addrDetect && nineBit && charNinth && !rxFlag) |=> rxFlag && received_ninth_bit)
		else $error("Address character not loaded");
	a_ninth_bit: assert property (@(posedge sys_clk) disable iff (!rst_n) // R08
		loadChar |=> received_ninth_bit == $past(charNinth) && rxData == $past(charByte)) else $error("Ninth bit mismatch");
	a_continuous_receive_enable_clear: assert property (@(posedge sys_clk) disable iff (!rst_n) // R10
		!contEnable |=> !overrun_error && !framing_error) else $error("Errors kept after receive disable");
	a_sleep_idle: assert property (@(posedge sys_clk) disable iff (!rst_n) // R11
		sleepReq |=> rxState == RX_IDLE) else $error("Reception active in sleep");
	a_wake_idle: assert property (@(posedge sys_clk) disable iff (!rst_n) // R12
		wakeEnable [*2] |-> rxState == RX_IDLE) else $error("Reception active with wake enabled");
	a_wake_flag: assert property (@(posedge sys_clk) disable iff (!rst_n) // R13 R14
		seqWakeFall |=> rxFlag && wakeSeen) else $error("Wake event did not set flag");
	a_wake_end: assert property (@(posedge sys_clk) disable iff (!rst_n) // R16
		seqWakeRise and !wrDone |=> !wakeEnable && !wakeSeen) else $error("Wake enable not cleared");
	a_flag_read: assert property (@(posedge sys_clk) disable iff (!rst_n) // R15
		(dataRead && !loadChar && !fallEdge) |=> !rxFlag) else $error("Flag survived data read");
endmodule
`default_nettype wire

// ---- uarx_regs.svh ----
// Register offsets, field positions, reset values and timing counts of the receive port
`ifndef UARX_REGS_SVH
`define UARX_REGS_SVH

// ==========================================================
// Register byte offsets
`define UARX_OFF_RX_STATUS 8'h00
`define UARX_OFF_RX_DATA 8'h04
`define UARX_OFF_TX_STATUS 8'h08
`define UARX_OFF_BAUD_CTRL 8'h0C
`define UARX_OFF_DIV_HIGH 8'h10
`define UARX_OFF_DIV_LOW 8'h14
`define UARX_OFF_INT_CTRL 8'h18

// ==========================================================
// Receive status and control fields
`define UARX_RS_PORT_EN 7
`define UARX_RS_NINE_EN 6
`define UARX_RS_CONT_EN 4
`define UARX_RS_ADDR_EN 3
`define UARX_RS_FRAME_ERR 2
`define UARX_RS_OVER_ERR 1
`define UARX_RS_NINTH 0

// Transmit status and control fields used by the receiver
`define UARX_TS_SYNC 4
`define UARX_TS_HIGH_SPEED 2

// Baud control fields
`define UARX_BC_IDLE 6
`define UARX_BC_SIXTEEN 3
`define UARX_BC_WAKE 1

// Interrupt control fields
`define UARX_IC_RX_IE 0
`define UARX_IC_RX_IP 1
`define UARX_IC_GLOBAL_IE 2

// ==========================================================
// Reset values
`define UARX_RST_BYTE 8'h00
`define UARX_RST_WORD 32'h0000_0000

// ==========================================================
// Timing counts, in sample ticks and data bits
`define UARX_OVERSAMPLE 16
`define UARX_TICK_LAST 4'hF
`define UARX_TICK_MID 4'h7
`define UARX_LAST_BIT8 4'h7
`define UARX_LAST_BIT9 4'h8

`endif

// ---- uarx_pkg.sv ----
// Types shared by the receive port design
`default_nettype none
package uarx_pkg;

	typedef enum logic [2:0] {
		RX_IDLE,
		RX_START,
		RX_DATA,
		RX_STOP
	} uarx_state_t;

endpackage
`default_nettype wire

// ---- uarx_baud.sv ----
// Sample tick generator running at sixteen times the bit rate
`timescale 1ns/1ps
`default_nettype none
module uarx_baud (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Control
	input wire logic run,
	input wire logic fastMode,
	input wire logic [15:0] divisor,
	// Sample tick
	output logic tick
);
	logic [17:0] cnt;
	logic [17:0] next_cnt;
	logic next_tick;
	logic [17:0] limit;

	// ==========================================================
	// Divider
	always_comb begin
		// Slow mode stretches each tick by four for the coarse range
		limit = fastMode ? {2'b00, divisor} : {divisor, 2'b11};
		next_cnt = cnt;
		next_tick = 1'b0;
		if (!run) begin
			next_cnt = 18'h0_0000;
		end else if (cnt >= limit) begin
			next_cnt = 18'h0_0000;
			next_tick = 1'b1;
		end else begin
			next_cnt = cnt + 18'h0_0001;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			cnt <= 18'h0_0000;
			tick <= 1'b0;
		end else begin
			cnt <= next_cnt;
			tick <= next_tick;
		end
	end
endmodule
`default_nettype wire

// ---- uarx_line_model.sv ----
// Remote serial transmitter driving the receive line
`timescale 1ns/1ps
`default_nettype none
module uarx_line_model #(
	parameter int BIT_CLKS = 32
) (
	// Clock of the bench
	input wire logic sys_clk,
	// Serial line, idles high
	output logic rxLine
);
	initial rxLine = 1'b1;

	// ==========================================================
	// Line level primitive
	// Each hold starts on a fresh edge so no level is set twice in one step
	task automatic holdLevel(input logic lvl, input int clks);
		@(posedge sys_clk);
		rxLine <= lvl;
		repeat (clks - 1) @(posedge sys_clk);
	endtask

	// ==========================================================
	// Frames
	task automatic sendChar(input logic [8:0] val, input int nbits, input logic stopOk);
		holdLevel(1'b0, BIT_CLKS);
		for (int i = 0; i < nbits; i++) begin
			holdLevel(val[i], BIT_CLKS);
		end
		holdLevel(stopOk, BIT_CLKS);
		holdLevel(1'b1, BIT_CLKS);
	endtask

	// All-zero wake character held low for the given bits, two bit times of idle after it
	task automatic sendBreak(input int bits);
		holdLevel(1'b0, bits * BIT_CLKS);
		holdLevel(1'b1, 2 * BIT_CLKS);
	endtask
endmodule
`default_nettype wire

// ---- uarx_top_bench.sv ----
// Self-checking bench of the receive port
`timescale 1ns/1ps
`default_nettype none
`include "uarx_regs.svh"
module uarx_top_bench import uarx_pkg::*;;
	// ==========================================================
	// Signals
	logic sys_clk, rst_n, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic rxLine, sleepReq, rxIrq, rxIrqHighPri;
	int errTotal = 0;
	int numChecks = 0;

	uarx_top dut (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.rxLine(rxLine), .sleepReq(sleepReq), .rxIrq(rxIrq), .rxIrqHighPri(rxIrqHighPri));
	// Divisor 1 with high speed: two clocks a tick, 32 clocks a bit
	uarx_line_model #(.BIT_CLKS(32)) line (.sys_clk(sys_clk), .rxLine(rxLine));

	initial sys_clk = 1'b0;
	always #50 sys_clk = ~sys_clk;

	// ==========================================================
	// Shared tasks
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		numChecks++;
		if (got !== exp) begin
			errTotal++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] addr, input logic [7:0] wd,
			output logic [31:0] rd, output logic err);
		int n;
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= addr;
		pwdata <= {24'h00_0000, wd};
		@(posedge sys_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		chk("pready", 1'b1, pready);
	endtask

	task automatic wr(input logic [7:0] addr, input logic [7:0] wd);
		logic [31:0] rd;
		logic err;
		apb(1'b1, addr, wd, rd, err);
	endtask

	task automatic rdChk(input string what, input logic [7:0] addr, input logic [31:0] exp, input logic [31:0] mask);
		logic [31:0] rd;
		logic err;
		apb(1'b0, addr, 8'h00, rd, err);
		chk(what, exp, rd & mask);
	endtask

	task automatic waitIrq(input int lim);
		int n;
		n = 0;
		while (rxIrq !== 1'b1 && n < lim) begin
			@(posedge sys_clk);
			n++;
		end
		chk("rxIrq raised", 1'b1, rxIrq);
	endtask

	// ==========================================================
	// Scenarios
	task automatic testReset();
		logic [31:0] rd;
		logic err;
		rdChk("status reset", `UARX_OFF_RX_STATUS, 32'h0000_0000, 32'hFFFF_FFFF);
		rdChk("data reset", `UARX_OFF_RX_DATA, 32'h0000_0000, 32'hFFFF_FFFF);
		rdChk("divHigh reset", `UARX_OFF_DIV_HIGH, 32'h0000_0000, 32'hFFFF_FFFF);
		apb(1'b1, 8'h1C, 8'hFF, rd, err);
		chk("unmapped write err", 1'b1, err);
		apb(1'b0, 8'h1C, 8'h00, rd, err);
		chk("unmapped read", 32'h0000_0000, rd);
		$display("test reset done");
	endtask

	task automatic setup();
		wr(`UARX_OFF_DIV_HIGH, 8'h00);
		wr(`UARX_OFF_DIV_LOW, 8'h01);
		wr(`UARX_OFF_TX_STATUS, 8'h04);
		wr(`UARX_OFF_INT_CTRL, 8'h05);
	endtask

	task automatic testPlain();
		wr(`UARX_OFF_RX_STATUS, 8'h90);
		fork
			line.sendChar(9'h0A5, 8, 1'b1);
			begin
				repeat (100) @(posedge sys_clk);
				rdChk("idle mid frame", `UARX_OFF_BAUD_CTRL, 32'h0000_0000, 32'h0000_0040);
			end
		join
		waitIrq(60);
		chk("low priority", 1'b0, rxIrqHighPri);
		wr(`UARX_OFF_INT_CTRL, 8'h07);
		@(negedge sys_clk);
		chk("high priority", 1'b1, rxIrqHighPri);
		wr(`UARX_OFF_INT_CTRL, 8'h01);
		@(negedge sys_clk);
		chk("irq without global", 1'b0, rxIrq);
		wr(`UARX_OFF_INT_CTRL, 8'h05);
		rdChk("status plain", `UARX_OFF_RX_STATUS, 32'h0000_0090, 32'h0000_00FF);
		rdChk("idle after frame", `UARX_OFF_BAUD_CTRL, 32'h0000_0040, 32'h0000_0040);
		rdChk("data plain", `UARX_OFF_RX_DATA, 32'h0000_00A5, 32'hFFFF_FFFF);
		@(negedge sys_clk);
		chk("irq after read", 1'b0, rxIrq);
		$display("test plain done");
	endtask

	task automatic testAddr();
		// Nine-bit first, then address detect, continuous receive last
		wr(`UARX_OFF_RX_STATUS, 8'hC0);
		wr(`UARX_OFF_RX_STATUS, 8'hC8);
		wr(`UARX_OFF_RX_STATUS, 8'hD8);
		line.sendChar(9'h033, 9, 1'b1);
		repeat (20) @(posedge sys_clk);
		chk("data char dropped", 1'b0, rxIrq);
		line.sendChar(9'h15A, 9, 1'b1);
		waitIrq(60);
		rdChk("ninth bit", `UARX_OFF_RX_STATUS, 32'h0000_00D9, 32'h0000_00FF);
		rdChk("address", `UARX_OFF_RX_DATA, 32'h0000_005A, 32'h0000_00FF);
		wr(`UARX_OFF_RX_STATUS, 8'hD0);
		line.sendChar(9'h03C, 9, 1'b1);
		waitIrq(60);
		rdChk("ninth zero", `UARX_OFF_RX_STATUS, 32'h0000_00D0, 32'h0000_00FF);
		rdChk("data after detect", `UARX_OFF_RX_DATA, 32'h0000_003C, 32'h0000_00FF);
		$display("test address done");
	endtask

	task automatic testFrame();
		wr(`UARX_OFF_RX_STATUS, 8'h90);
		line.sendChar(9'h0F0, 8, 1'b0);
		waitIrq(60);
		rdChk("framing flag", `UARX_OFF_RX_STATUS, 32'h0000_0094, 32'h0000_00FF);
		rdChk("framing data", `UARX_OFF_RX_DATA, 32'h0000_00F0, 32'h0000_00FF);
		wr(`UARX_OFF_RX_STATUS, 8'h80);
		rdChk("error cleared", `UARX_OFF_RX_STATUS, 32'h0000_0080, 32'h0000_00FF);
		// Second character arrives before the first is read
		wr(`UARX_OFF_RX_STATUS, 8'h90);
		line.sendChar(9'h011, 8, 1'b1);
		line.sendChar(9'h022, 8, 1'b1);
		rdChk("overrun flag", `UARX_OFF_RX_STATUS, 32'h0000_0092, 32'h0000_00FF);
		rdChk("overrun keeps first", `UARX_OFF_RX_DATA, 32'h0000_0011, 32'h0000_00FF);
		wr(`UARX_OFF_RX_STATUS, 8'h80);
		rdChk("overrun cleared", `UARX_OFF_RX_STATUS, 32'h0000_0080, 32'h0000_00FF);
		$display("test framing done");
	endtask

	task automatic testModes();
		wr(`UARX_OFF_BAUD_CTRL, 8'h08);
		wr(`UARX_OFF_TX_STATUS, 8'h00);
		wr(`UARX_OFF_RX_STATUS, 8'h90);
		rdChk("sixteen-bit select", `UARX_OFF_BAUD_CTRL, 32'h0000_0048, 32'h0000_00FF);
		line.sendChar(9'h04B, 8, 1'b1);
		waitIrq(60);
		rdChk("data sixteen-bit", `UARX_OFF_RX_DATA, 32'h0000_004B, 32'h0000_00FF);
		// Synchronous select must keep the receiver idle
		wr(`UARX_OFF_TX_STATUS, 8'h10);
		line.sendChar(9'h066, 8, 1'b1);
		repeat (20) @(posedge sys_clk);
		chk("no rx in sync mode", 1'b0, rxIrq);
		rdChk("data kept in sync", `UARX_OFF_RX_DATA, 32'h0000_004B, 32'h0000_00FF);
		wr(`UARX_OFF_TX_STATUS, 8'h04);
		wr(`UARX_OFF_BAUD_CTRL, 8'h00);
		$display("test modes done");
	endtask

	task automatic testWake();
		@(posedge sys_clk);
		sleepReq <= 1'b1;
		wr(`UARX_OFF_RX_STATUS, 8'h90);
		line.sendChar(9'h055, 8, 1'b1);
		repeat (20) @(posedge sys_clk);
		chk("no rx in sleep", 1'b0, rxIrq);
		wr(`UARX_OFF_BAUD_CTRL, 8'h02);
		fork
			line.sendBreak(12);
			begin
				repeat (20) @(posedge sys_clk);
				chk("wake flag", 1'b1, rxIrq);
				rdChk("wake held low line", `UARX_OFF_BAUD_CTRL, 32'h0000_0002, 32'h0000_0002);
			end
		join
		rdChk("wake auto clear", `UARX_OFF_BAUD_CTRL, 32'h0000_0000, 32'h0000_0002);
		rdChk("data kept over wake", `UARX_OFF_RX_DATA, 32'h0000_004B, 32'h0000_00FF);
		@(negedge sys_clk);
		chk("wake flag cleared", 1'b0, rxIrq);
		@(posedge sys_clk);
		sleepReq <= 1'b0;
		$display("test wake done");
	endtask

	// ==========================================================
	// Closing and sequencing
	task automatic wrapUp();
		$display("checks %0d mismatches %0d", numChecks, errTotal);
		if (errTotal == 0 && numChecks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// Whole run is some 4300 cycles; over five times that is a hang
	// Limit kept well above the longest path through all scenarios
	initial begin
		repeat (24000) @(posedge sys_clk);
		errTotal++;
		$display("BAD watchdog expected end seen timeout");
		wrapUp();
	end

	initial begin
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		sleepReq = 1'b0;
		repeat (8) @(posedge sys_clk);
		rst_n <= 1'b1;
		testReset();
		setup();
		testPlain();
		testAddr();
		testFrame();
		testModes();
		testWake();
		wrapUp();
	end
endmodule
`default_nettype wire
